// File: design/uart_irq_status.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module uart_irq_status
  import uart_irq_pkg::*;
#(
  parameter int CNT_W     = 7,
  parameter bit HAS_MODEM = 1'b1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             thr_write,
  input  wire logic             tx_fifo_full,
  input  wire logic             tx_last_to_shift,
  input  wire logic             rx_fifo_push,
  input  wire logic             rbr_read,
  input  wire logic [CNT_W-1:0] rx_fifo_count,
  input  wire logic [CNT_W-1:0] rx_trigger_level,
  input  wire logic             timeout_match,
  input  wire logic             rx_overflow_event,
  input  wire logic             rx_break_event,
  input  wire logic             rx_framing_event,
  input  wire logic             rx_parity_event,
  input  wire logic             rx_address_event,
  input  wire logic             lin_break_event,
  input  wire logic             cts_pin,
  output logic [7:0]            channel_indicators,
  output logic                  uart_irq,
  output logic                  event_irq
);

  logic [7:0]        aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              aw_done;
  logic              w_done;
  logic              wr_fire;
  logic [31:0]       wr_mask;
  logic              rd_take;
  logic [1:0]        control;
  logic [7:0]        enable;
  logic [7:0]        event_mask;
  logic [7:0]        event_status;
  logic [7:0]        routed_prev;
  logic              tx_holding_empty_flag;
  logic              rx_data_avail_flag;
  logic              rx_timeout_flag;
  logic              cts_meta;
  logic              cts_sync;
  logic              cts_prev;
  logic              cts_primed;
  logic [1:0]        cts_warm;
  logic [BANK_W-1:0] bank_set;
  logic [BANK_W-1:0] bank_clear;
  logic [BANK_W-1:0] bank;
  logic              dma_mode;
  logic              rs485_mode;
  logic              rx_line_status_flag;
  logic              buffer_error_flag;
  logic              modem_change_flag;
  logic [7:0]        sw_flags;
  logic [7:0]        dma_flags;
  logic [7:0]        sw_enable;
  logic [7:0]        dma_enable;
  logic [7:0]        sw_ind;
  logic [7:0]        dma_ind;
  logic [7:0]        routed_ind;
  logic [31:0]       int_status;
  logic [31:0]       rd_value;
  logic              rd_hit;

  assign dma_mode   = control[CTRL_DMA];
  assign rs485_mode = control[CTRL_RS485];

  // Write channel: address and data taken in either order
  assign wr_fire = aw_done && w_done && !s_axi_bvalid;
  assign wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_done       <= 1'b0;
      aw_addr_q     <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_done       <= 1'b1;
      aw_addr_q     <= s_axi_awaddr;
    end else begin
      s_axi_awready <= !aw_done && !s_axi_bvalid && !wr_fire;
      if (wr_fire) aw_done <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_done       <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_done       <= 1'b1;
      w_data_q     <= s_axi_wdata;
      w_strb_q     <= s_axi_wstrb;
    end else begin
      s_axi_wready <= !w_done && !s_axi_bvalid && !wr_fire;
      if (wr_fire) w_done <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr_q[7:2])
        OFS_CONTROL[7:2], OFS_ENABLE[7:2], OFS_MODEM[7:2], OFS_FIFO_ERR[7:2],
        OFS_INT_STATUS[7:2], OFS_EVENT[7:2], OFS_EVENT_MASK[7:2]: s_axi_bresp <= RESP_OKAY;
        default: s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software-written configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control    <= CONTROL_RESET;
      enable     <= ENABLE_RESET;
      event_mask <= MASK_RESET;
    end else if (wr_fire && w_strb_q[0]) begin
      if (aw_addr_q[7:2] == OFS_CONTROL[7:2]) control <= w_data_q[1:0];
      if (aw_addr_q[7:2] == OFS_ENABLE[7:2]) enable <= w_data_q[7:0];
      if (aw_addr_q[7:2] == OFS_EVENT_MASK[7:2]) event_mask <= w_data_q[7:0];
    end
  end

  // CTS pin synchroniser; a pin idling high must not fake a change after reset,
  // so change detect waits until both compared stages hold real pin samples
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cts_meta   <= 1'b0;
      cts_sync   <= 1'b0;
      cts_prev   <= 1'b0;
      cts_warm   <= 2'h0;
      cts_primed <= 1'b0;
    end else begin
      cts_meta   <= cts_pin;
      cts_sync   <= cts_meta;
      cts_prev   <= cts_sync;
      cts_warm   <= {cts_warm[0], 1'b1};
      cts_primed <= cts_warm[1];
    end
  end

  // Sticky flags set by events, cleared by writing one
  always_comb begin
    bank_set             = '0;
    bank_clear           = '0;
    bank_set[BK_RX_OVER] = rx_overflow_event;
    bank_set[BK_ADDR]    = rx_address_event && rs485_mode;
    bank_set[BK_PARITY]  = rx_parity_event;
    bank_set[BK_FRAMING] = rx_framing_event;
    bank_set[BK_BREAK]   = rx_break_event;
    bank_set[BK_TX_OVER] = thr_write && tx_fifo_full;
    bank_set[BK_CTS]     = HAS_MODEM && cts_primed && (cts_sync != cts_prev);
    bank_set[BK_LINBRK]  = lin_break_event;
    if (wr_fire) begin
      if (aw_addr_q[7:2] == OFS_FIFO_ERR[7:2]) begin
        bank_clear[BK_RX_OVER] = w_data_q[ERR_RX_OVER] && wr_mask[ERR_RX_OVER];
        bank_clear[BK_ADDR]    = w_data_q[ERR_ADDR] && wr_mask[ERR_ADDR];
        bank_clear[BK_PARITY]  = w_data_q[ERR_PARITY] && wr_mask[ERR_PARITY];
        bank_clear[BK_FRAMING] = w_data_q[ERR_FRAMING] && wr_mask[ERR_FRAMING];
        bank_clear[BK_BREAK]   = w_data_q[ERR_BREAK] && wr_mask[ERR_BREAK];
        bank_clear[BK_TX_OVER] = w_data_q[ERR_TX_OVER] && wr_mask[ERR_TX_OVER];
      end
      if (aw_addr_q[7:2] == OFS_MODEM[7:2]) begin
        bank_clear[BK_CTS] = w_data_q[MDM_CTS_DETECT] && wr_mask[MDM_CTS_DETECT];
      end
      if (aw_addr_q[7:2] == OFS_INT_STATUS[7:2]) begin
        bank_clear[BK_LINBRK] = w_data_q[FLG_LINBRK] && wr_mask[FLG_LINBRK];
      end
    end
  end

  w1c_flag_bank #(.WIDTH(BANK_W)) u_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (bank_set),
    .clear   (bank_clear),
    .flags   (bank)
  );

  // Holding empty: a set in the same cycle as a write wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_holding_empty_flag <= INT_STATUS_RESET[FLG_THRE];
    end else if (tx_last_to_shift) begin
      tx_holding_empty_flag <= 1'b1;
    end else if (thr_write) begin
      tx_holding_empty_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_avail_flag <= INT_STATUS_RESET[FLG_RDA];
    end else begin
      rx_data_avail_flag <= (rx_fifo_count >= rx_trigger_level);
    end
  end

  // Any FIFO activity both blocks the set and clears the flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_timeout_flag <= INT_STATUS_RESET[FLG_TOUT];
    end else if (rbr_read || rx_fifo_push || rx_fifo_count == '0) begin
      rx_timeout_flag <= 1'b0;
    end else if (timeout_match) begin
      rx_timeout_flag <= 1'b1;
    end
  end

  assign buffer_error_flag   = bank[BK_TX_OVER] || bank[BK_RX_OVER];
  assign rx_line_status_flag = bank[BK_BREAK] || bank[BK_FRAMING] || bank[BK_PARITY]
                               || (rs485_mode && bank[BK_ADDR]);
  assign modem_change_flag   = HAS_MODEM && bank[BK_CTS];

  always_comb begin
    sw_flags              = 8'h00;
    sw_flags[FLG_RDA]     = rx_data_avail_flag;
    sw_flags[FLG_THRE]    = tx_holding_empty_flag;
    sw_flags[FLG_RLS]     = rx_line_status_flag;
    sw_flags[FLG_MODEM]   = modem_change_flag;
    sw_flags[FLG_TOUT]    = rx_timeout_flag;
    sw_flags[FLG_BUFERR]  = buffer_error_flag;
    sw_flags[FLG_LINBRK]  = bank[BK_LINBRK];
    dma_flags             = sw_flags;
    dma_flags[FLG_RDA]    = 1'b0;
    dma_flags[FLG_THRE]   = 1'b0;
    sw_enable             = enable;
    sw_enable[EN_DMA_TOUT] = 1'b0;
    dma_enable            = enable;
    dma_enable[FLG_TOUT]  = enable[EN_DMA_TOUT];
    dma_enable[EN_DMA_TOUT] = 1'b0;
    dma_enable[FLG_RDA]   = 1'b0;
    dma_enable[FLG_THRE]  = 1'b0;
  end

  assign sw_ind     = sw_flags & sw_enable;
  assign dma_ind    = dma_flags & dma_enable;
  assign routed_ind = dma_mode ? dma_ind : sw_ind;
  assign int_status = {dma_ind, dma_flags, sw_ind, sw_flags};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_indicators <= 8'h00;
      uart_irq           <= 1'b0;
    end else begin
      channel_indicators <= routed_ind;
      uart_irq           <= |routed_ind;
    end
  end

  // Rising indicators latch into the event register; read clears, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      routed_prev  <= 8'h00;
      event_status <= 8'h00;
      event_irq    <= 1'b0;
    end else begin
      routed_prev  <= routed_ind;
      event_status <= (rd_take && s_axi_araddr[7:2] == OFS_EVENT[7:2] ? 8'h00 : event_status)
                      | (routed_ind & ~routed_prev);
      event_irq    <= |(event_status & event_mask);
    end
  end

  // Read channel
  assign rd_take = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_value = 32'h0000_0000;
    rd_hit   = 1'b1;
    case (s_axi_araddr[7:2])
      OFS_CONTROL[7:2]:    rd_value[1:0] = control;
      OFS_ENABLE[7:2]:     rd_value[7:0] = enable;
      OFS_MODEM[7:2]: begin
        rd_value[MDM_CTS_DETECT] = modem_change_flag;
        rd_value[MDM_CTS_STATE]  = HAS_MODEM && cts_sync;
      end
      OFS_FIFO_ERR[7:2]: begin
        rd_value[ERR_RX_OVER] = bank[BK_RX_OVER];
        rd_value[ERR_ADDR]    = bank[BK_ADDR];
        rd_value[ERR_PARITY]  = bank[BK_PARITY];
        rd_value[ERR_FRAMING] = bank[BK_FRAMING];
        rd_value[ERR_BREAK]   = bank[BK_BREAK];
        rd_value[ERR_TX_OVER] = bank[BK_TX_OVER];
      end
      OFS_INT_STATUS[7:2]: rd_value = int_status;
      OFS_EVENT[7:2]:      rd_value[7:0] = event_status;
      OFS_EVENT_MASK[7:2]: rd_value[7:0] = event_mask;
      default:             rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_value;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sw_active;
    !dma_mode && (|sw_ind);
  endsequence

  sequence s_dma_active;
    dma_mode && (|dma_ind);
  endsequence

  sequence s_cts_edge;
    HAS_MODEM && cts_primed && (cts_sync != cts_prev);
  endsequence

  AST_SW_IND: assert property (s_sw_active |=> uart_irq)
    else $error("software indicator did not raise request");
  AST_DMA_IND: assert property (s_dma_active |=> uart_irq)
    else $error("DMA indicator did not raise request");
  AST_ROUTE: assert property (dma_mode |=> channel_indicators == $past(dma_ind))
    else $error("DMA indicators not routed");
  AST_RESET_VAL: assert property ($past(!aresetn) |-> int_status == INT_STATUS_RESET)
    else $error("status register reset value wrong");
  AST_BUF_ERR: assert property (rx_overflow_event |=> sw_flags[FLG_BUFERR] && dma_flags[FLG_BUFERR])
    else $error("buffer error not set by overflow");
  AST_TOUT_SET: assert property ((timeout_match && rx_fifo_count != '0 && !rx_fifo_push
                                  && !rbr_read) |=> rx_timeout_flag)
    else $error("timeout flag not set");
  AST_TOUT_CLR: assert property ((rx_fifo_push || rbr_read) |=> !rx_timeout_flag)
    else $error("timeout flag not cleared by activity");
  AST_CTS: assert property (s_cts_edge |=> modem_change_flag)
    else $error("modem flag missed CTS change");
  AST_THRE: assert property (tx_last_to_shift |=> tx_holding_empty_flag)
    else $error("holding empty flag not set");
  AST_THRE_CLR: assert property ((thr_write && !tx_last_to_shift) |=> !tx_holding_empty_flag)
    else $error("holding empty flag not cleared by write");
  AST_RDA: assert property (rx_fifo_count >= rx_trigger_level |=> rx_data_avail_flag)
    else $error("data available flag missed trigger level");
  AST_LIN: assert property ((bank_clear[BK_LINBRK] && !lin_break_event)
                            |=> !sw_flags[FLG_LINBRK] && !dma_flags[FLG_LINBRK])
    else $error("LIN break flags not cleared");
  AST_NO_MODEM: assert property (!HAS_MODEM |-> !int_status[DMA_FLG_LSB+FLG_MODEM] && !sw_flags[FLG_MODEM])
    else $error("modem flag on modemless channel");

endmodule

// File: design/uart_irq_pkg.sv
package uart_irq_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_ENABLE     = 8'h04;
  localparam logic [7:0] OFS_MODEM      = 8'h14;
  localparam logic [7:0] OFS_FIFO_ERR   = 8'h18;
  localparam logic [7:0] OFS_INT_STATUS = 8'h1c;
  localparam logic [7:0] OFS_EVENT      = 8'h30;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h34;

  localparam logic [31:0] INT_STATUS_RESET = 32'h0000_0002;
  localparam logic [7:0]  ENABLE_RESET     = 8'h00;
  localparam logic [7:0]  MASK_RESET       = 8'h00;
  localparam logic [1:0]  CONTROL_RESET    = 2'h0;

  // Flag positions inside one byte of the interrupt status register
  localparam int FLG_RDA    = 0;
  localparam int FLG_THRE   = 1;
  localparam int FLG_RLS    = 2;
  localparam int FLG_MODEM  = 3;
  localparam int FLG_TOUT   = 4;
  localparam int FLG_BUFERR = 5;
  localparam int FLG_LINBRK = 7;
  localparam int EN_DMA_TOUT = 6;

  // Byte lanes of the interrupt status register
  localparam int SW_IND_LSB   = 8;
  localparam int DMA_FLG_LSB  = 16;
  localparam int DMA_IND_LSB  = 24;

  // Control register bits
  localparam int CTRL_DMA   = 0;
  localparam int CTRL_RS485 = 1;

  // Modem register bits
  localparam int MDM_CTS_DETECT = 0;
  localparam int MDM_CTS_STATE  = 4;

  // FIFO error register bits
  localparam int ERR_RX_OVER = 0;
  localparam int ERR_ADDR    = 3;
  localparam int ERR_PARITY  = 4;
  localparam int ERR_FRAMING = 5;
  localparam int ERR_BREAK   = 6;
  localparam int ERR_TX_OVER = 24;

  // Index of each sticky flag inside the flag bank
  localparam int BK_RX_OVER = 0;
  localparam int BK_ADDR    = 1;
  localparam int BK_PARITY  = 2;
  localparam int BK_FRAMING = 3;
  localparam int BK_BREAK   = 4;
  localparam int BK_TX_OVER = 5;
  localparam int BK_CTS     = 6;
  localparam int BK_LINBRK  = 7;
  localparam int BANK_W     = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: design/w1c_flag_bank.sv
`timescale 1ns/100ps

module w1c_flag_bank #(
  parameter int WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clear,
  output logic      [WIDTH-1:0] flags
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      // A set in the clearing cycle wins so no event is lost
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flags[i] <= 1'b0;
        end else if (set[i]) begin
          flags[i] <= 1'b1;
        end else if (clear[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// File: tb/irq_ctrl_model.sv
`timescale 1ns/100ps

module irq_ctrl_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       irq_in,
  output logic      [7:0] rises
);
  logic last;

  // Counts rising edges only; a level held high across reset is counted again, as last restarts at 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last  <= 1'b0;
      rises <= 8'h00;
    end else begin
      last <= irq_in;
      if (irq_in && !last) begin
        rises <= rises + 8'h01;
      end
    end
  end
endmodule

// File: tb/testbench.sv
`timescale 1ns/100ps

`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin errors++; \
  $display("FAIL %s expected %h seen %h", n, e, g); end end

module testbench;
  import uart_irq_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic        awready, wready, arready, txf, cts, uirq, eirq;
  logic [7:0]  awaddr, araddr, chan, f, en, rises;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  strb;
  logic [6:0]  cnt, lvl;
  logic [10:0] evt;
  logic        dma;
  int          errors, checked, cyc, i, k, seed;

  uart_irq_status u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .thr_write(evt[6]), .tx_fifo_full(txf), .tx_last_to_shift(evt[7]),
    .rx_fifo_push(evt[8]), .rbr_read(evt[9]), .rx_fifo_count(cnt),
    .rx_trigger_level(lvl), .timeout_match(evt[10]), .rx_overflow_event(evt[0]),
    .rx_break_event(evt[1]), .rx_framing_event(evt[2]), .rx_parity_event(evt[3]),
    .rx_address_event(evt[4]), .lin_break_event(evt[5]), .cts_pin(cts),
    .channel_indicators(chan), .uart_irq(uirq), .event_irq(eirq)
  );

  irq_ctrl_model u_irq_ctrl (.aclk(aclk), .aresetn(aresetn), .irq_in(eirq), .rises(rises));

  always #12.5 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Master holds each channel until its own ready; response taken when seen
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        b = 1'b1;
        rsp = bresp;
        bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic ev(input int n);
    @(posedge aclk);
    evt[n] <= 1'b1;
    @(posedge aclk);
    evt <= '0;
  endtask

  // DMA lane hides rda/thre and uses the DMA timeout enable
  function automatic logic [31:0] exp_isr(input logic [7:0] fl, input logic [7:0] ie);
    logic [7:0] df;
    logic [7:0] de;
    df = fl & 8'hfc;
    de = {ie[7:5], ie[6], ie[3:0]};
    return {df & de, df, fl & ie, fl};
  endfunction

  task automatic chk_isr();
    logic [31:0] e;
    logic [31:0] v;
    logic [1:0]  rsp;
    repeat (3) @(posedge aclk);
    rd(OFS_INT_STATUS, v, rsp);
    e = exp_isr(f, en);
    `CHK("status", e, v)
    `CHK("routed", (dma ? e[31:24] : e[15:8]), chan)
    `CHK("irq", (|(dma ? e[31:24] : e[15:8])), uirq)
  endtask

  initial begin
    seed = 84409;
    aclk = 0;
    aresetn = 0;
    {awvalid, wvalid, bready, arvalid, rready, txf, cts} = '0;
    awaddr = 0;
    araddr = 0;
    wdata = 0;
    strb = 4'hf;
    evt = 0;
    cnt = 0;
    lvl = 7'h10;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    f = 8'h02;
    en = 8'h00;
    dma = 0;
    chk_isr();
    rd(8'h08, d, r);
    `CHK("unmapped", RESP_SLVERR, r)
    wr(8'h08, 32'h0000_00ff, r);
    `CHK("unmapped write", RESP_SLVERR, r)
    wr(OFS_ENABLE, 32'h0000_00ff, r);
    `CHK("write resp", RESP_OKAY, r)
    en = 8'hff;
    chk_isr();
    // All lanes off: the enable register must keep its value
    strb <= 4'h0;
    wr(OFS_ENABLE, 32'h0000_0000, r);
    strb <= 4'hf;
    chk_isr();
    ev(6);
    f[1] = 0;
    chk_isr();
    ev(7);
    f[1] = 1;
    chk_isr();
    for (i = 0; i < 6; i++) begin
      k = 1 + ($unsigned($random(seed)) % 3);
      ev(k);
      f[2] = 1;
      chk_isr();
      wr(OFS_FIFO_ERR, 32'h1 << (7 - k), r);
      f[2] = 0;
      chk_isr();
    end
    ev(4);
    chk_isr();
    wr(OFS_CONTROL, 32'h2, r);
    ev(4);
    f[2] = 1;
    chk_isr();
    wr(OFS_FIFO_ERR, 32'h8, r);
    f[2] = 0;
    chk_isr();
    ev(0);
    f[5] = 1;
    chk_isr();
    txf <= 1'b1;
    ev(6);
    txf <= 1'b0;
    f[1] = 0;
    wr(OFS_FIFO_ERR, 32'h1, r);
    chk_isr();
    wr(OFS_FIFO_ERR, 32'h0100_0000, r);
    f[5] = 0;
    chk_isr();
    cnt <= 7'h03;
    ev(10);
    f[4] = 1;
    chk_isr();
    ev(9);
    f[4] = 0;
    chk_isr();
    ev(10);
    ev(8);
    chk_isr();
    ev(10);
    cnt <= 7'h00;
    chk_isr();
    cnt <= lvl;
    f[0] = 1;
    chk_isr();
    cnt <= lvl - 7'h01;
    f[0] = 0;
    chk_isr();
    cnt <= 7'h00;
    cts <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(OFS_MODEM, d, r);
    `CHK("cts change", 1'b1, d[MDM_CTS_DETECT])
    f[3] = 1;
    chk_isr();
    wr(OFS_MODEM, 32'h1, r);
    f[3] = 0;
    chk_isr();
    ev(5);
    f[7] = 1;
    chk_isr();
    wr(OFS_INT_STATUS, 32'h80, r);
    f[7] = 0;
    chk_isr();
    wr(OFS_CONTROL, 32'h1, r);
    dma = 1;
    ev(3);
    f[2] = 1;
    chk_isr();
    wr(OFS_FIFO_ERR, 32'h10, r);
    f[2] = 0;
    chk_isr();
    wr(OFS_CONTROL, 32'h0, r);
    dma = 0;
    repeat (3) @(posedge aclk);
    rd(OFS_EVENT, d, r);
    wr(OFS_EVENT_MASK, 32'h4, r);
    ev(3);
    repeat (3) @(posedge aclk);
    `CHK("event irq", 1'b1, eirq)
    rd(OFS_EVENT, d, r);
    `CHK("event status", 8'h04, d[7:0])
    repeat (2) @(posedge aclk);
    `CHK("event irq clear", 1'b0, eirq)
    wr(OFS_EVENT_MASK, 32'h0, r);
    wr(OFS_FIFO_ERR, 32'h10, r);
    ev(2);
    repeat (3) @(posedge aclk);
    `CHK("event masked", 1'b0, eirq)
    rd(OFS_EVENT, d, r);
    `CHK("masked status", 8'h04, d[7:0])
    `CHK("ctrl rises", 8'h01, rises)
    print_verdict();
  end
endmodule
